// File: rtl/psw_pkg.sv
// Package for the processor supervisor watchdog: register map, reset values,
// timing constants and state encodings.
// Assumes a single 200 MHz clock and an APB register slave.
package psw_pkg;
    localparam int CLK_MHZ = 200;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int HOLD_MS = 250;
    localparam int WD_250_MS = 250;
    localparam int WD_500_MS = 500;
    localparam int WD_1000_MS = 1000;
    localparam int OSC_START_MS = 100;
    localparam logic [11:0] OFF_WATCHDOG = 12'h000;
    localparam logic [11:0] OFF_CONTROL = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [1:0] TIMEOUT_SEL_RESET = 2'h3;
    localparam logic OSC_DISABLE_RESET = 1'b1;
    localparam int OSC_DISABLE_BIT = 0;
    localparam logic [1:0] SEL_OFF = 2'h0;
    localparam logic [1:0] SEL_250 = 2'h1;
    localparam logic [1:0] SEL_500 = 2'h2;

    typedef enum logic [2:0] {
        PSW_POWER_HOLD = 3'h0,
        PSW_RUN = 3'h1,
        PSW_DEBOUNCE = 3'h2,
        PSW_WAIT_RELEASE = 3'h3,
        PSW_RESET_HOLD = 3'h4
    } psw_state_t;
endpackage

// File: rtl/psw_sync.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to pclk.
`timescale 1ns/1ps
`default_nettype none
module psw_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic first;
        logic second;
    } psw_sync_t;
    psw_sync_t r;
    psw_sync_t next_r;

    always_comb begin
        next_r.first = async_in;
        next_r.second = r.first;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= {RESET_VALUE, RESET_VALUE};
        end else begin
            r <= next_r;
        end
    end

    assign sync_out = r.second;
endmodule
`default_nettype wire

// File: rtl/psw_tick.sv
// Millisecond tick divider standing in for the timekeeping oscillator.
// Assumes pclk at the rate given in the package.
`timescale 1ns/1ps
`default_nettype none
module psw_tick #(
    parameter int DIVIDE = psw_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Tick
    output logic tick
);
    // The 24-bit counter cannot serve a longer divide
    if (DIVIDE < 2 || DIVIDE > 16777215) begin : g_bad_divide
        $error("psw_tick divide out of range");
    end

    typedef struct packed {
        logic [23:0] count;
        logic pulse;
    } psw_tick_t;
    psw_tick_t r;
    psw_tick_t next_r;

    always_comb begin
        next_r = r;
        next_r.pulse = 1'b0;
        if (r.count == 24'(DIVIDE - 1)) begin
            next_r.count = 24'h000000;
            next_r.pulse = 1'b1;
        end else begin
            next_r.count = r.count + 24'h000001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick = r.pulse;
endmodule
`default_nettype wire

// File: rtl/psw_top.sv
// Processor supervisor: reset hold, pushbutton debounce and watchdog.
// Assumes supply_fail, watchdog_kick and the reset pin come from outside
// the clock domain; registers are reached over APB.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module psw_top #(
    parameter int TICK_DIVIDE = psw_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Supervisor pins
    input wire logic supply_fail,
    input wire logic on_battery,
    input wire logic watchdog_kick,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    output logic osc_standby
);
    typedef struct packed {
        psw_pkg::psw_state_t state;
        logic [10:0] ms;
        logic [1:0] timeout_sel;
        logic osc_disable;
        logic kick_d;
        logic pin_d;
        logic drive;
        logic [31:0] rdata;
    } psw_regs_t;
    psw_regs_t r;
    psw_regs_t next_r;

    logic tick;
    logic fail_s;
    logic kick_s;
    logic pin_s;
    logic batt_s;
    logic [10:0] wd_limit;
    logic [10:0] hold_limit;
    logic kick_fall;
    logic pin_fall;
    logic pin_rise;
    logic apb_access;
    logic apb_write;
    logic addr_ok;

    psw_tick #(.DIVIDE(TICK_DIVIDE)) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );
    psw_sync #(.RESET_VALUE(1'b1)) u_fail (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(supply_fail),
        .sync_out(fail_s)
    );
    psw_sync #(.RESET_VALUE(1'b1)) u_kick (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(watchdog_kick),
        .sync_out(kick_s)
    );
    psw_sync #(.RESET_VALUE(1'b1)) u_pin (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(rst_pin_in),
        .sync_out(pin_s)
    );
    // Battery flag is a pin too, so it is synced before it gates standby
    psw_sync #(.RESET_VALUE(1'b0)) u_batt (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(on_battery),
        .sync_out(batt_s)
    );

    always_comb begin
        case (r.timeout_sel)
            psw_pkg::SEL_250: wd_limit = 11'(psw_pkg::WD_250_MS);
            psw_pkg::SEL_500: wd_limit = 11'(psw_pkg::WD_500_MS);
            default: wd_limit = 11'(psw_pkg::WD_1000_MS);
        endcase
    end

    // Oscillator start-up is only modelled as a fixed extra hold
    assign hold_limit = r.osc_disable ?
        11'(psw_pkg::HOLD_MS + psw_pkg::OSC_START_MS) :
        11'(psw_pkg::HOLD_MS);

    // Edge flops reset high like the kick and pin syncs, so reset gives no false edge;
    // the pin is low during power hold, where a fall is ignored anyway
    assign kick_fall = r.kick_d && !kick_s;
    assign pin_fall = r.pin_d && !pin_s;
    assign pin_rise = !r.pin_d && pin_s;
    assign apb_access = psel && penable;
    assign apb_write = apb_access && pwrite;
    assign addr_ok = paddr == psw_pkg::OFF_WATCHDOG ||
        paddr == psw_pkg::OFF_CONTROL || paddr == psw_pkg::OFF_STATUS;

    always_comb begin
        next_r = r;
        next_r.kick_d = kick_s;
        next_r.pin_d = pin_s;
        if (tick) begin
            next_r.ms = r.ms + 11'h001;
        end
        case (r.state)
            psw_pkg::PSW_POWER_HOLD: begin
                next_r.drive = 1'b1;
                if (r.ms >= hold_limit) begin
                    next_r.state = psw_pkg::PSW_RUN;
                    next_r.drive = 1'b0;
                    next_r.ms = 11'h000;
                end
            end
            psw_pkg::PSW_RUN: begin
                if (kick_fall || r.timeout_sel == psw_pkg::SEL_OFF) begin
                    next_r.ms = 11'h000;
                end
                if (pin_fall) begin
                    next_r.state = psw_pkg::PSW_DEBOUNCE;
                    next_r.drive = 1'b1;
                    next_r.ms = 11'h000;
                end else if (r.timeout_sel != psw_pkg::SEL_OFF &&
                        !kick_fall && r.ms >= wd_limit) begin
                    next_r.state = psw_pkg::PSW_RESET_HOLD;
                    next_r.drive = 1'b1;
                    next_r.ms = 11'h000;
                end
            end
            psw_pkg::PSW_DEBOUNCE: begin
                if (r.ms >= 11'(psw_pkg::HOLD_MS)) begin
                    next_r.drive = 1'b0;
                    next_r.ms = 11'h000;
                    next_r.state = psw_pkg::PSW_WAIT_RELEASE;
                end
            end
            psw_pkg::PSW_WAIT_RELEASE: begin
                // Pin reads low for up to two ticks after release of drive
                if (r.ms >= 11'h002 && pin_s) begin
                    next_r.state = psw_pkg::PSW_RESET_HOLD;
                    next_r.drive = 1'b1;
                    next_r.ms = 11'h000;
                end else if (pin_rise) begin
                    next_r.state = psw_pkg::PSW_RESET_HOLD;
                    next_r.drive = 1'b1;
                    next_r.ms = 11'h000;
                end else if (r.ms < 11'h002) begin
                    next_r.ms = r.ms + 11'(tick);
                end
            end
            psw_pkg::PSW_RESET_HOLD: begin
                if (r.ms >= 11'(psw_pkg::HOLD_MS)) begin
                    next_r.state = psw_pkg::PSW_RUN;
                    next_r.drive = 1'b0;
                    next_r.ms = 11'h000;
                end
            end
            default: begin
                next_r.state = psw_pkg::PSW_POWER_HOLD;
            end
        endcase
        if (fail_s) begin
            next_r.state = psw_pkg::PSW_POWER_HOLD;
            next_r.drive = 1'b1;
            next_r.ms = 11'h000;
        end
        if (apb_write && paddr == psw_pkg::OFF_WATCHDOG) begin
            next_r.timeout_sel = pwdata[1:0];
        end
        if (apb_write && paddr == psw_pkg::OFF_CONTROL) begin
            next_r.osc_disable = pwdata[psw_pkg::OSC_DISABLE_BIT];
        end
        next_r.rdata = 32'h00000000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                psw_pkg::OFF_WATCHDOG:
                    next_r.rdata = {30'h0, r.timeout_sel};
                psw_pkg::OFF_CONTROL:
                    next_r.rdata = {31'h0, r.osc_disable};
                psw_pkg::OFF_STATUS:
                    next_r.rdata = {27'h0, pin_s, r.drive, r.state};
                default: next_r.rdata = 32'h00000000;
            endcase
        end else if (apb_access) begin
            next_r.rdata = r.rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.state <= psw_pkg::PSW_POWER_HOLD;
            r.ms <= 11'h000;
            r.timeout_sel <= psw_pkg::TIMEOUT_SEL_RESET;
            r.osc_disable <= psw_pkg::OSC_DISABLE_RESET;
            r.kick_d <= 1'b1;
            r.pin_d <= 1'b1;
            r.drive <= 1'b1;
            r.rdata <= 32'h00000000;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.rdata;
    assign pready = 1'b1;
    assign pslverr = apb_access && !addr_ok;
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe = r.drive;
    assign osc_standby = r.osc_disable && batt_s;

    fail_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        fail_s |=> rst_pin_oe)
        else $error("reset not driven on supply fail");
    power_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(fail_s) |=> rst_pin_oe [*8])
        else $error("power hold released early");
    debounce_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.state == psw_pkg::PSW_RUN && pin_fall && !fail_s)
        |=> r.state == psw_pkg::PSW_DEBOUNCE && rst_pin_oe)
        else $error("button edge not debounced");
    wd_expire_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.state == psw_pkg::PSW_RUN && r.ms >= wd_limit && !kick_fall &&
        !pin_fall && !fail_s && r.timeout_sel != 2'h0)
        |=> r.state == psw_pkg::PSW_RESET_HOLD)
        else $error("watchdog expiry missed");
    wd_disable_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.state == psw_pkg::PSW_RUN && r.timeout_sel == 2'h0 && !fail_s &&
        !pin_fall) |=> r.state == psw_pkg::PSW_RUN)
        else $error("disabled watchdog fired");
    kick_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.state == psw_pkg::PSW_RUN && kick_fall && !pin_fall && !fail_s)
        |=> r.ms == 11'h000)
        else $error("kick did not restart count");
    hold_time_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.state == psw_pkg::PSW_RESET_HOLD && r.ms < 11'(psw_pkg::HOLD_MS))
        |=> rst_pin_oe)
        else $error("reset hold ended early");
    release_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.state == psw_pkg::PSW_RESET_HOLD &&
        r.ms >= 11'(psw_pkg::HOLD_MS) && !fail_s)
        |=> !rst_pin_oe && r.state == psw_pkg::PSW_RUN)
        else $error("reset not released after hold");
    standby_a: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_write && paddr == psw_pkg::OFF_CONTROL &&
        pwdata[psw_pkg::OSC_DISABLE_BIT])
        |=> osc_standby == batt_s)
        else $error("standby does not follow disable bit");
    power_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.state == psw_pkg::PSW_POWER_HOLD && r.osc_disable &&
        r.ms < 11'(psw_pkg::HOLD_MS + psw_pkg::OSC_START_MS))
        |=> rst_pin_oe)
        else $error("start-up extension cut short");
    power_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.state == psw_pkg::PSW_POWER_HOLD && r.ms >= hold_limit &&
        !fail_s) |=> !rst_pin_oe && r.state == psw_pkg::PSW_RUN)
        else $error("power hold not released");
    debounce_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.state == psw_pkg::PSW_DEBOUNCE &&
        r.ms < 11'(psw_pkg::HOLD_MS)) |=> rst_pin_oe)
        else $error("debounce drive dropped early");
    debounce_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.state == psw_pkg::PSW_DEBOUNCE &&
        r.ms >= 11'(psw_pkg::HOLD_MS) && !fail_s)
        |=> !rst_pin_oe && r.state == psw_pkg::PSW_WAIT_RELEASE)
        else $error("pin not resampled after debounce");
    release_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.state == psw_pkg::PSW_WAIT_RELEASE && pin_rise && !fail_s)
        |=> rst_pin_oe && r.state == psw_pkg::PSW_RESET_HOLD)
        else $error("release did not start reset hold");
    wd_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.state == psw_pkg::PSW_RUN && r.timeout_sel != psw_pkg::SEL_OFF &&
        tick && !kick_fall && !pin_fall && !fail_s && r.ms < wd_limit)
        |=> r.ms == $past(r.ms) + 11'h001)
        else $error("watchdog count stalled");
    wd_off_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.state == psw_pkg::PSW_RUN && r.timeout_sel == psw_pkg::SEL_OFF &&
        !pin_fall && !fail_s) |=> r.ms == 11'h000)
        else $error("disabled watchdog kept counting");
    wd_fire_c: cover property (@(posedge pclk) disable iff (!presetn)
        r.state == psw_pkg::PSW_RUN ##1 r.state == psw_pkg::PSW_RESET_HOLD);
    button_c: cover property (@(posedge pclk) disable iff (!presetn)
        r.state == psw_pkg::PSW_WAIT_RELEASE ##1
        r.state == psw_pkg::PSW_RESET_HOLD);
    power_c: cover property (@(posedge pclk) disable iff (!presetn)
        r.state == psw_pkg::PSW_POWER_HOLD ##1 r.state == psw_pkg::PSW_RUN);
    kick_c: cover property (@(posedge pclk) disable iff (!presetn)
        r.state == psw_pkg::PSW_RUN && kick_fall && r.ms != 11'h000);
    fail_c: cover property (@(posedge pclk) disable iff (!presetn)
        r.state == psw_pkg::PSW_RUN && fail_s);
endmodule
`default_nettype wire

// File: bench/psw_host_model.sv
// Host model: kicks the watchdog and presses a switch on the reset pin.
// Assumes the reset pin is open drain with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module psw_host_model #(
    parameter int KICK_CYCLES = 600
) (
    // Clock
    input wire logic pclk,
    // Bench controls
    input wire logic keep_alive,
    input wire logic button_down,
    // Supervisor side
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe,
    output logic watchdog_kick,
    output logic rst_pin_in
);
    int cnt = 0;
    // Pull-up wins unless the device or the switch pulls the pin low
    assign rst_pin_in = !((rst_pin_oe && !rst_pin_out) || button_down);
    // Kick well inside the shortest period; pulse far wider than needed
    always @(posedge pclk) begin
        if (!keep_alive) begin
            cnt <= 0;
            watchdog_kick <= 1'b1;
        end else begin
            cnt <= (cnt == KICK_CYCLES + 4) ? 0 : cnt + 1;
            watchdog_kick <= (cnt < KICK_CYCLES);
        end
    end
endmodule
`default_nettype wire

// File: bench/psw_top_tb.sv
// Bench for the supervisor: registers, power hold, watchdog, pushbutton
// and supply failure. Assumes a shortened tick of T clock cycles.
`timescale 1ns/1ps
`default_nettype none
module psw_top_tb;
    localparam int T = 4;
    logic pclk, presetn, psel, penable, pwrite, supply_fail, on_battery;
    logic keep_alive, button_down, watchdog_kick, rst_pin_in, err;
    logic pready, pslverr, rst_pin_out, rst_pin_oe, osc_standby;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int miscompares, n_compared, n;

    psw_top #(.TICK_DIVIDE(T)) i_psw_top(.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .supply_fail(supply_fail),
        .on_battery(on_battery), .watchdog_kick(watchdog_kick),
        .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
        .rst_pin_oe(rst_pin_oe), .osc_standby(osc_standby));
    psw_host_model #(.KICK_CYCLES(150 * T)) i_psw_host_model(.pclk(pclk),
        .keep_alive(keep_alive), .button_down(button_down),
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
        .watchdog_kick(watchdog_kick), .rst_pin_in(rst_pin_in));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One bounded clock step; running out ends the run as a failure
    task automatic step(input int hi);
        @(posedge pclk);
        n++;
        if (n > hi) begin
            miscompares++;
            summarize();
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do step(20); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Bounds are in ticks; the slack covers tick phase and synchronisers
    task automatic wait_oe(input logic v, input int lo, input int hi);
        n = 0;
        while (rst_pin_oe !== v) step(hi * T + 10);
        check(32'(n >= lo * T), 32'h1);
    endtask

    task automatic wait_kick();
        keep_alive <= 1'b1;
        n = 0;
        while (watchdog_kick !== 1'b0) step(2000);
        keep_alive <= 1'b0;
    endtask

    task automatic t_regs();
        check(32'(rst_pin_oe), 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h3);
        check(32'(err), 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h8);
        apb(1'b0, 12'h00C, 32'h0);
        check(rd, 32'h0);
        check(32'(err), 32'h1);
        on_battery <= 1'b1;
        apb(1'b1, 12'h004, 32'h1);
        check(32'(osc_standby), 32'h1);
        on_battery <= 1'b0;
    endtask

    task automatic t_watchdog();
        for (int k = 1; k <= 3; k++) begin
            int p;
            p = 250 << (k - 1);
            apb(1'b1, 12'h000, 32'(k));
            apb(1'b0, 12'h000, 32'h0);
            check(rd, 32'(k));
            wait_kick();
            wait_oe(1'b1, p - 2, p + 2);
            wait_oe(1'b0, 248, 252);
        end
        apb(1'b1, 12'h000, 32'h0);
        repeat (1200 * T) @(posedge pclk);
        check(32'(rst_pin_oe), 32'h0);
    endtask

    task automatic t_button();
        button_down <= 1'b1;
        wait_oe(1'b1, 0, 2);
        check(32'(rst_pin_out), 32'h0);
        wait_oe(1'b0, 248, 252);
        repeat (100 * T) @(posedge pclk);
        check(32'(rst_pin_oe), 32'h0);
        button_down <= 1'b0;
        wait_oe(1'b1, 0, 2);
        wait_oe(1'b0, 248, 252);
    endtask

    // Oscillator enabled, so this hold lacks the start-up extension
    task automatic t_supply();
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h0);
        supply_fail <= 1'b1;
        wait_oe(1'b1, 0, 0);
        repeat (300 * T) @(posedge pclk);
        check(32'(rst_pin_oe), 32'h1);
        supply_fail <= 1'b0;
        wait_oe(1'b0, 248, 252);
    endtask

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {supply_fail, on_battery, keep_alive, button_down} = '0;
        miscompares = 0;
        n_compared = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        wait_oe(1'b0, 340, 352);
        t_watchdog();
        t_button();
        t_supply();
        summarize();
    end
endmodule
`default_nettype wire
